/* File: src/rhcd_decoder.sv */
// holds: host command decoder with its configuration and user registers
// assumes: host characters arrive as a valid/ready byte stream; tag functions
// answer each dispatched operation except continuous read with a done pulse, an error flag and a reply byte
`timescale 1ns/10ps
module rhcd_decoder
    import rhcd_pkg::*;
#(
    parameter int FIFO_DEPTH = 16,
    parameter int LED_HOLD = rhcd_pkg::LED_HOLD_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] host_rx_data,
    input wire logic host_rx_valid,
    output logic host_rx_ready,
    output logic [7:0] host_tx_data,
    output logic host_tx_valid,
    input wire logic host_tx_ready,
    input wire logic reg_write,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic [3:0] op_code,
    output logic op_start,
    input wire logic op_done,
    input wire logic op_error,
    input wire logic op_silent,
    input wire logic [7:0] op_reply,
    input wire logic cont_read_abort,
    input wire logic [7:0] key_transfer_tag_status,
    input wire logic key_transfer_tag_active,
    output logic timeout_from_timers,
    output logic page_read_mode,
    output logic [7:0] page_start,
    output logic [7:0] page_count,
    output logic request_reply_extended_ident,
    output logic cont_read_active,
    output logic led_green,
    output logic led_red
);
    import rhcd_pkg::*;

    // -------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------
    logic [7:0] protocol_config_three;
    logic [7:0] user_scratch_area [USER_DEPTH];
    logic user_hit;
    logic [6:0] user_index;

    assign user_hit = (reg_addr >= ADDR_USER_FIRST) && (reg_addr <= ADDR_USER_LAST);
    assign user_index = 7'(reg_addr - ADDR_USER_FIRST);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            protocol_config_three <= RESET_PROTOCOL_CONFIG_THREE;
        end else if (reg_write && reg_addr == ADDR_PROTOCOL_CONFIG_THREE) begin
            protocol_config_three <= reg_wdata & MASK_WRITABLE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            page_start <= RESET_PAGE;
            page_count <= RESET_PAGE;
        end else if (reg_write && reg_addr == ADDR_PAGE_START) begin
            page_start <= reg_wdata;
        end else if (reg_write && reg_addr == ADDR_PAGE_COUNT) begin
            page_count <= reg_wdata;
        end
    end

    // storage only, feeds nothing but the read port
    always_ff @(posedge ref_clk) begin
        if (reg_write && user_hit) begin
            user_scratch_area[user_index] <= reg_wdata;
        end
    end

    always_comb begin
        if (reg_addr == ADDR_PROTOCOL_CONFIG_THREE) begin
            reg_rdata = protocol_config_three;
        end else if (reg_addr == ADDR_PAGE_START) begin
            reg_rdata = page_start;
        end else if (reg_addr == ADDR_PAGE_COUNT) begin
            reg_rdata = page_count;
        end else if (user_hit) begin
            reg_rdata = user_scratch_area[user_index];
        end else begin
            reg_rdata = 8'h00;
        end
    end

    assign timeout_from_timers = protocol_config_three[BIT_TIMEOUT_FROM_TIMERS];
    assign page_read_mode = protocol_config_three[BIT_PAGE_READ];
    assign request_reply_extended_ident = protocol_config_three[BIT_REQUEST_REPLY_EXTENDED_IDENT];

    // -------------------------------------------------------------------
    // receive path through the fifo
    // -------------------------------------------------------------------
    logic [7:0] rx_data;
    logic rx_valid;
    logic rx_take;
    rhcd_state_t state;
    logic [7:0] first_char;
    logic reply_busy;

    rhcd_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_data(host_rx_data),
        .in_valid(host_rx_valid),
        .in_ready(host_rx_ready),
        .out_data(rx_data),
        .out_valid(rx_valid),
        .out_ready(rx_take)
    );

    // characters are consumed only while the reply slot is free
    assign rx_take = rx_valid && !reply_busy && (state == RHCD_IDLE || state == RHCD_SECOND || state == RHCD_CONT);

    // -------------------------------------------------------------------
    // decode
    // -------------------------------------------------------------------
    rhcd_op_t next_op;
    logic single_known;
    logic pair_first;

    always_comb begin
        single_known = 1'b0;
        pair_first = 1'b0;
        unique case (rx_data)
            CH_QUERY, CH_PLUS, CH_EQUAL, CH_C: single_known = 1'b1;
            CH_D, CH_P, CH_U, CH_I: pair_first = 1'b1;
            default: ;
        endcase
    end

    always_comb begin
        next_op = RHCD_OP_NONE;
        if (state == RHCD_IDLE) begin
            if (rx_data == CH_QUERY) next_op = RHCD_OP_QUERY;
            else if (rx_data == CH_PLUS) next_op = RHCD_OP_CREDIT;
            else if (rx_data == CH_EQUAL) next_op = RHCD_OP_BACKUP;
            else if (rx_data == CH_C) next_op = RHCD_OP_CONT_READ;
        end else begin
            if (first_char == CH_D && rx_data == CH_S) next_op = RHCD_OP_CIPHER;
            else if (first_char == CH_P && rx_data == CH_R) next_op = RHCD_OP_PORT_READ;
            else if (first_char == CH_P && rx_data == CH_W) next_op = RHCD_OP_PORT_WRITE;
            else if (first_char == CH_U && rx_data == CH_A) next_op = RHCD_OP_RIGHTS_UPDATE;
            else if (first_char == CH_I && rx_data == CH_A) next_op = RHCD_OP_RIGHTS_REPORT;
        end
    end

    // -------------------------------------------------------------------
    // command sequencer
    // -------------------------------------------------------------------
    logic reply_load;
    logic [7:0] reply_value;
    logic result_ok;
    logic result_err;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= RHCD_IDLE;
            first_char <= 8'h00;
            op_code <= RHCD_OP_NONE;
        end else begin
            unique case (state)
                RHCD_IDLE: begin
                    if (rx_take) begin
                        first_char <= rx_data;
                        if (rx_data == CH_QUERY) begin
                            state <= RHCD_IDLE;
                        end else if (single_known) begin
                            op_code <= next_op;
                            state <= RHCD_EXEC;
                        end else if (pair_first) begin
                            state <= RHCD_SECOND;
                        end
                    end
                end
                RHCD_SECOND: begin
                    if (rx_take) begin
                        if (next_op != RHCD_OP_NONE) begin
                            op_code <= next_op;
                            state <= RHCD_EXEC;
                        end else begin
                            state <= RHCD_IDLE;
                        end
                    end
                end
                RHCD_EXEC: begin
                    state <= (op_code == RHCD_OP_CONT_READ) ? RHCD_CONT : RHCD_WAIT;
                end
                RHCD_WAIT: begin
                    if (op_done) begin
                        state <= RHCD_IDLE;
                    end
                end
                RHCD_CONT: begin
                    if (rx_take || cont_read_abort) begin
                        state <= RHCD_IDLE;
                    end
                end
                default: state <= RHCD_IDLE;
            endcase
        end
    end

    assign op_start = (state == RHCD_EXEC);
    assign cont_read_active = (state == RHCD_CONT);

    // reply chosen for each ending of a command except a continuous read abort or an op_silent completion, which send none
    always_comb begin
        reply_load = 1'b0;
        reply_value = 8'h00;
        result_ok = 1'b0;
        result_err = 1'b0;
        if (state == RHCD_IDLE && rx_take && rx_data == CH_QUERY) begin
            reply_load = 1'b1;
            reply_value = key_transfer_tag_active ? key_transfer_tag_status : REPLY_FAIL;
            result_ok = 1'b1;
        end else if (state == RHCD_IDLE && rx_take && !single_known && !pair_first) begin
            reply_load = 1'b1;
            reply_value = REPLY_UNKNOWN;
            result_err = 1'b1;
        end else if (state == RHCD_SECOND && rx_take && next_op == RHCD_OP_NONE) begin
            reply_load = 1'b1;
            reply_value = REPLY_UNKNOWN;
            result_err = 1'b1;
        end else if (state == RHCD_WAIT && op_done) begin
            reply_load = !op_silent;
            reply_value = op_reply;
            result_ok = !op_error;
            result_err = op_error;
        end else if (state == RHCD_CONT && rx_take) begin
            reply_load = 1'b1;
            reply_value = REPLY_STOPPED;
            result_ok = 1'b1;
        end
    end

    // a query during continuous read also stops it; the reply is REPLY_ACTIVE instead of REPLY_STOPPED
    // -------------------------------------------------------------------
    // reply holding register
    // -------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            host_tx_valid <= 1'b0;
            host_tx_data <= 8'h00;
        end else if (reply_load) begin
            host_tx_valid <= 1'b1;
            host_tx_data <= (state == RHCD_CONT && rx_data == CH_QUERY) ? REPLY_ACTIVE : reply_value;
        end else if (host_tx_ready) begin
            host_tx_valid <= 1'b0;
        end
    end

    assign reply_busy = host_tx_valid && !host_tx_ready;

    // -------------------------------------------------------------------
    // indicators
    // -------------------------------------------------------------------
    logic [$clog2(LED_HOLD+1)-1:0] led_timer;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            led_green <= 1'b0;
            led_red <= 1'b0;
            led_timer <= '0;
        end else if (result_ok || result_err) begin
            led_green <= result_ok;
            led_red <= result_err;
            led_timer <= ($clog2(LED_HOLD+1))'(LED_HOLD);
        end else if (led_timer != '0) begin
            led_timer <= led_timer - 1'b1;
        end else begin
            led_green <= 1'b0;
            led_red <= 1'b0;
        end
    end
endmodule

/* File: src/rhcd_pkg.sv */
// package: register map, field positions, command codes and states of the command decoder
// assumes: one 10 MHz clock, synchronous active-high reset
package rhcd_pkg;
    // -------------------------------------------------------------------
    // register map
    // -------------------------------------------------------------------
    localparam logic [7:0] ADDR_PROTOCOL_CONFIG_THREE = 8'h1B;
    localparam logic [7:0] ADDR_PAGE_START = 8'h1C;
    localparam logic [7:0] ADDR_PAGE_COUNT = 8'h1F;
    localparam logic [7:0] ADDR_USER_FIRST = 8'h80;
    localparam logic [7:0] ADDR_USER_LAST = 8'hEF;
    localparam logic [7:0] RESET_PROTOCOL_CONFIG_THREE = 8'h00;
    localparam logic [7:0] RESET_PAGE = 8'h00;
    localparam int USER_DEPTH = 112;

    // -------------------------------------------------------------------
    // field positions of protocol_config_three
    // -------------------------------------------------------------------
    localparam int BIT_TIMEOUT_FROM_TIMERS = 0;
    localparam int BIT_PAGE_READ = 2;
    localparam int BIT_REQUEST_REPLY_EXTENDED_IDENT = 6;
    localparam logic [7:0] MASK_WRITABLE = 8'h7D;

    // -------------------------------------------------------------------
    // command characters and replies
    // -------------------------------------------------------------------
    localparam logic [7:0] CH_QUERY = 8'h21;
    localparam logic [7:0] CH_PLUS = 8'h2B;
    localparam logic [7:0] CH_EQUAL = 8'h3D;
    localparam logic [7:0] CH_D = 8'h64;
    localparam logic [7:0] CH_S = 8'h73;
    localparam logic [7:0] CH_P = 8'h70;
    localparam logic [7:0] CH_R = 8'h72;
    localparam logic [7:0] CH_W = 8'h77;
    localparam logic [7:0] CH_U = 8'h75;
    localparam logic [7:0] CH_I = 8'h69;
    localparam logic [7:0] CH_A = 8'h61;
    localparam logic [7:0] CH_C = 8'h63;
    localparam logic [7:0] REPLY_STOPPED = 8'h53;
    localparam logic [7:0] REPLY_UNKNOWN = 8'h3F;
    localparam logic [7:0] REPLY_ACTIVE = 8'h69;
    localparam logic [7:0] REPLY_FAIL = 8'h46;

    typedef enum logic [3:0] {
        RHCD_OP_NONE = 4'h0,
        RHCD_OP_QUERY = 4'h1,
        RHCD_OP_CIPHER = 4'h2,
        RHCD_OP_PORT_READ = 4'h3,
        RHCD_OP_PORT_WRITE = 4'h4,
        RHCD_OP_CREDIT = 4'h5,
        RHCD_OP_BACKUP = 4'h6,
        RHCD_OP_RIGHTS_UPDATE = 4'h7,
        RHCD_OP_RIGHTS_REPORT = 4'h8,
        RHCD_OP_CONT_READ = 4'h9
    } rhcd_op_t;

    typedef enum logic [2:0] {
        RHCD_IDLE = 3'b000,
        RHCD_SECOND = 3'b001,
        RHCD_EXEC = 3'b010,
        RHCD_WAIT = 3'b011,
        RHCD_CONT = 3'b100
    } rhcd_state_t;

    // indicator hold, 100 ms at 10 MHz
    localparam int CLK_HZ = 10_000_000;
    localparam int LED_HOLD_MS = 100;
    localparam int LED_HOLD_CYCLES = CLK_HZ / 1000 * LED_HOLD_MS;
endpackage

/* File: src/rhcd_fifo.sv */
// holds: parameterised synchronous fifo with valid/ready on both sides
// assumes: single clock, synchronous active-high reset
`timescale 1ns/10ps
module rhcd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count <= '0;
        end else if (push && !pop) begin
            count <= count + 1'b1;
        end else if (pop && !push) begin
            count <= count - 1'b1;
        end
    end
endmodule

/* File: verification/rhcd_decoder_chk.sv */
// checker: concurrent properties on the command decoder ports
// assumes: bound to rhcd_decoder, one clock ref_clk, sync reset rst
`timescale 1ns/10ps
module rhcd_decoder_chk
    import rhcd_pkg::*;
#(
    parameter int FIFO_DEPTH = 16,
    parameter int LED_HOLD = LED_HOLD_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] host_rx_data,
    input wire logic host_rx_valid,
    input wire logic host_rx_ready,
    input wire logic [7:0] host_tx_data,
    input wire logic host_tx_valid,
    input wire logic reg_write,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic op_done,
    input wire logic op_error,
    input wire logic op_silent,
    input wire logic [7:0] op_reply,
    input wire logic cont_read_abort,
    input wire logic timeout_from_timers,
    input wire logic page_read_mode,
    input wire logic [7:0] page_start,
    input wire logic [7:0] page_count,
    input wire logic request_reply_extended_ident,
    input wire logic cont_read_active,
    input wire logic led_green,
    input wire logic led_red
);
    // ----
    // properties
    // ----
    default clocking dcb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_reply(logic [7:0] b);
        host_tx_valid && host_tx_data == b;
    endsequence
    sequence s_quiet;
        !cont_read_active && !host_tx_valid;
    endsequence
    property p_reset_cfg;
        disable iff (1'b0) rst |=> !timeout_from_timers && !page_read_mode && !request_reply_extended_ident
            && page_start == 8'h00 && page_count == 8'h00 && !host_tx_valid && !led_green && !led_red;
    endproperty
    property p_cfg_write;
        reg_write && reg_addr == ADDR_PROTOCOL_CONFIG_THREE |=> ($past(reg_wdata) & 8'h45) ==
            {1'b0, request_reply_extended_ident, 3'b000, page_read_mode, 1'b0, timeout_from_timers};
    endproperty
    property p_page;
        reg_write && reg_addr == ADDR_PAGE_START |=> page_start == $past(reg_wdata);
    endproperty
    property p_user_inert;
        reg_write && reg_addr >= ADDR_USER_FIRST && reg_addr <= ADDR_USER_LAST |=> $stable(page_start)
            && $stable(page_count) && $stable(timeout_from_timers) && $stable(page_read_mode);
    endproperty
    property p_op_reply;
        op_done && !op_error && !op_silent && !cont_read_active |=> s_reply($past(op_reply)) ##0 led_green;
    endproperty
    property p_op_error;
        op_done && op_error && !op_silent |=> led_red;
    endproperty
    property p_silent;
        op_done && op_silent && !host_tx_valid |=> !host_tx_valid [*3];
    endproperty
    property p_stop_reply;
        cont_read_active && host_rx_valid && host_rx_ready && host_rx_data != CH_QUERY && !host_tx_valid
            |-> ##[1:4] s_reply(REPLY_STOPPED);
    endproperty
    property p_abort;
        cont_read_active && cont_read_abort && !host_rx_valid && !host_tx_valid |-> ##[1:3] s_quiet;
    endproperty
    a_reset_cfg: assert property (p_reset_cfg) else $error("config not cleared by reset");
    a_cfg_write: assert property (p_cfg_write) else $error("config field outputs wrong");
    a_page: assert property (p_page) else $error("page start not taken");
    a_user_inert: assert property (p_user_inert) else $error("user write changed config");
    a_op_reply: assert property (p_op_reply) else $error("no reply or green after op");
    a_op_error: assert property (p_op_error) else $error("red not lit on error");
    a_silent: assert property (p_silent) else $error("silent op replied");
    a_stop_reply: assert property (p_stop_reply) else $error("stop reply missing");
    a_abort: assert property (p_abort) else $error("abort did not end quietly");
endmodule

/* File: verification/rhcd_host_model.sv */
// host model: sends command characters and takes reply bytes
// assumes: bench calls send_char and take_reply; lines change at falling edge
`timescale 1ns/10ps
module rhcd_host_model (
    input wire logic ref_clk,
    output logic [7:0] host_rx_data,
    output logic host_rx_valid,
    input wire logic host_rx_ready,
    input wire logic [7:0] host_tx_data,
    input wire logic host_tx_valid,
    output logic host_tx_ready
);
    int stall = 0;
    initial begin
        host_rx_data = 8'h00;
        host_rx_valid = 1'b0;
        host_tx_ready = 1'b0;
    end
    // char held until ready seen at a rising edge
    task automatic send_char(input logic [7:0] c, output bit ok);
        int n;
        n = 0;
        @(negedge ref_clk);
        host_rx_data = c;
        host_rx_valid = 1'b1;
        @(posedge ref_clk);
        while (host_rx_ready !== 1'b1 && n < 100) begin
            n++;
            @(posedge ref_clk);
        end
        ok = (n < 100);
        @(negedge ref_clk);
        host_rx_valid = 1'b0;
        host_rx_data = ~c; // released line shows no stale value
    endtask
    task automatic take_reply(input int limit, output logic [7:0] b, output bit got);
        int n;
        n = 0;
        got = 1'b0;
        b = 8'h00;
        repeat (stall) @(negedge ref_clk);
        @(negedge ref_clk);
        host_tx_ready = 1'b1;
        while (!got && n < limit) begin
            @(posedge ref_clk);
            n++;
            got = (host_tx_valid === 1'b1);
            b = host_tx_data;
        end
        @(negedge ref_clk);
        host_tx_ready = 1'b0;
    endtask
endmodule

/* File: verification/rhcd_decoder_tb.sv */
// testbench: register, command, continuous read and fifo scenarios
// assumes: package, design, checker and host model compiled first
`timescale 1ns/10ps
module rhcd_decoder_tb;
    import rhcd_pkg::*;
    localparam int LED_HOLD = 10;
    localparam int FIFO_DEPTH = 16;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] host_rx_data, host_tx_data, reg_rdata, page_start, page_count;
    logic host_rx_valid, host_rx_ready, host_tx_valid, host_tx_ready, op_start, timeout_from_timers;
    logic page_read_mode, request_reply_extended_ident, cont_read_active, led_green, led_red;
    logic [3:0] op_code, last_op = 4'h0;
    logic reg_write = 1'b0, op_done = 1'b0, op_error = 1'b0, op_silent = 1'b0, cont_read_abort = 1'b0;
    logic key_transfer_tag_active = 1'b0, resp_err = 1'b0, resp_sil = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, op_reply = 8'h00, key_transfer_tag_status = 8'h00;
    int miscompares = 0, num_checks = 0, cycles = 0, starts = 0, resp_delay = 2;
    logic [7:0] c1s [7] = '{CH_PLUS, CH_EQUAL, CH_D, CH_P, CH_P, CH_U, CH_I};
    logic [7:0] c2s [7] = '{8'h00, 8'h00, CH_S, CH_R, CH_W, CH_A, CH_A};
    rhcd_op_t ops [7] = '{RHCD_OP_CREDIT, RHCD_OP_BACKUP, RHCD_OP_CIPHER, RHCD_OP_PORT_READ,
        RHCD_OP_PORT_WRITE, RHCD_OP_RIGHTS_UPDATE, RHCD_OP_RIGHTS_REPORT};

    rhcd_decoder #(.FIFO_DEPTH(FIFO_DEPTH), .LED_HOLD(LED_HOLD)) dut (.ref_clk, .rst, .host_rx_data,
        .host_rx_valid, .host_rx_ready, .host_tx_data, .host_tx_valid, .host_tx_ready, .reg_write, .reg_addr,
        .reg_wdata, .reg_rdata, .op_code, .op_start, .op_done, .op_error, .op_silent, .op_reply,
        .cont_read_abort, .key_transfer_tag_status, .key_transfer_tag_active, .timeout_from_timers,
        .page_read_mode, .page_start, .page_count, .request_reply_extended_ident, .cont_read_active,
        .led_green, .led_red);
    rhcd_host_model host (.ref_clk, .host_rx_data, .host_rx_valid, .host_rx_ready, .host_tx_data,
        .host_tx_valid, .host_tx_ready);

    initial forever #50 ref_clk = ~ref_clk;

    // ----
    // checking and run control
    // ----
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp, input string what);
        chk8({7'h00, got}, {7'h00, exp}, what);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            $display("CHECK FAILED t=%0t run too long", $time);
            give_verdict();
        end
    end

    // ----
    // bus tasks
    // ----
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_write = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge ref_clk);
        reg_write = 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        reg_addr = a;
        @(negedge ref_clk);
        chk8(reg_rdata, exp, "register read");
    endtask
    task automatic send(input logic [7:0] c);
        bit ok;
        host.send_char(c, ok);
        chk1(ok, 1'b1, "char accepted");
    endtask
    task automatic expect_reply(input logic [7:0] exp, input logic present);
        logic [7:0] b;
        bit got;
        host.take_reply(present ? 100 : 20, b, got);
        chk1(got, present, "reply present");
        if (present) chk8(b, exp, "reply byte");
    endtask
    task automatic endt(input string name);
        $display("test %s done, mismatches so far %0d", name, miscompares);
    endtask

    // tag function side: answer every dispatched op except continuous read after resp_delay
    initial forever begin
        @(negedge ref_clk);
        if (op_start === 1'b1) begin
            last_op = op_code;
            starts++;
            if (op_code !== RHCD_OP_CONT_READ) begin
                repeat (resp_delay) @(negedge ref_clk);
                op_error = resp_err;
                op_silent = resp_sil;
                op_done = 1'b1;
                @(negedge ref_clk);
                op_done = 1'b0;
            end
        end
    end

    initial begin
        int n;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        rdchk(ADDR_PROTOCOL_CONFIG_THREE, RESET_PROTOCOL_CONFIG_THREE);
        rdchk(ADDR_PAGE_COUNT, RESET_PAGE);
        wr(ADDR_PROTOCOL_CONFIG_THREE, 8'h41);
        chk1(timeout_from_timers, 1'b1, "timer timeouts");
        chk1(request_reply_extended_ident, 1'b1, "extended ident");
        chk1(page_read_mode, 1'b0, "page read");
        wr(ADDR_PROTOCOL_CONFIG_THREE, 8'h04);
        chk1(page_read_mode, 1'b1, "page read");
        chk1(timeout_from_timers, 1'b0, "timer timeouts");
        rdchk(ADDR_PROTOCOL_CONFIG_THREE, 8'h04);
        wr(ADDR_PAGE_START, 8'h12);
        wr(ADDR_PAGE_COUNT, 8'h07);
        chk8(page_start, 8'h12, "page start");
        chk8(page_count, 8'h07, "page count");
        wr(ADDR_USER_FIRST, 8'hA5);
        wr(ADDR_USER_LAST, 8'h5A);
        wr(8'hF0, 8'hFF);
        rdchk(ADDR_USER_FIRST, 8'hA5);
        rdchk(ADDR_USER_LAST, 8'h5A);
        rdchk(8'hF0, 8'h00);
        rdchk(ADDR_PROTOCOL_CONFIG_THREE, 8'h04);
        endt("registers");
        for (int i = 0; i < 7; i++) begin
            op_reply = 8'hC0 + 8'(i);
            send(c1s[i]);
            if (c2s[i] != 8'h00) send(c2s[i]);
            expect_reply(op_reply, 1'b1);
            chk8({4'h0, last_op}, {4'h0, ops[i]}, "op code");
            chk1(led_green, 1'b1, "green");
        end
        resp_err = 1'b1;
        send(CH_PLUS);
        expect_reply(op_reply, 1'b1);
        chk1(led_red, 1'b1, "red");
        resp_err = 1'b0;
        resp_sil = 1'b1;
        send(CH_EQUAL);
        expect_reply(8'h00, 1'b0);
        resp_sil = 1'b0;
        send(CH_QUERY);
        expect_reply(REPLY_FAIL, 1'b1);
        key_transfer_tag_active = 1'b1;
        key_transfer_tag_status = 8'h02;
        send(CH_QUERY);
        expect_reply(8'h02, 1'b1);
        send(CH_D);
        send(8'h7A);
        expect_reply(REPLY_UNKNOWN, 1'b1);
        endt("commands");
        for (int m = 0; m < 3; m++) begin
            send(CH_C);
            for (int k = 0; k < 20 && cont_read_active !== 1'b1; k++) @(negedge ref_clk);
            chk1(cont_read_active, 1'b1, "continuous read on");
            if (m == 0) send(8'h78);
            if (m == 0) expect_reply(REPLY_STOPPED, 1'b1);
            if (m == 1) cont_read_abort = 1'b1;
            @(negedge ref_clk);
            cont_read_abort = 1'b0;
            if (m == 1) expect_reply(8'h00, 1'b0);
            if (m == 2) send(CH_QUERY);
            if (m == 2) expect_reply(REPLY_ACTIVE, 1'b1);
            chk1(cont_read_active, 1'b0, "continuous read off");
        end
        endt("continuous read");
        host.stall = 3;
        resp_delay = 60;
        op_reply = 8'h5E;
        n = starts;
        send(CH_PLUS);
        for (int k = 0; k < 20 && starts == n; k++) @(negedge ref_clk);
        for (int k = 0; k < FIFO_DEPTH; k++) send(8'h7A);
        @(negedge ref_clk);
        chk1(host_rx_ready, 1'b0, "fifo full");
        expect_reply(8'h5E, 1'b1);
        for (int k = 0; k < FIFO_DEPTH; k++) expect_reply(REPLY_UNKNOWN, 1'b1);
        chk1(host_rx_ready, 1'b1, "fifo drained");
        host.stall = 0;
        endt("fifo");
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        rdchk(ADDR_PROTOCOL_CONFIG_THREE, RESET_PROTOCOL_CONFIG_THREE);
        endt("second reset");
        give_verdict();
    end
endmodule

bind rhcd_decoder rhcd_decoder_chk #(.FIFO_DEPTH(FIFO_DEPTH), .LED_HOLD(LED_HOLD)) u_chk (.ref_clk, .rst,
    .host_rx_data, .host_rx_valid, .host_rx_ready, .host_tx_data, .host_tx_valid, .reg_write, .reg_addr,
    .reg_wdata, .op_done, .op_error, .op_silent, .op_reply, .cont_read_abort, .timeout_from_timers,
    .page_read_mode, .page_start, .page_count, .request_reply_extended_ident, .cont_read_active,
    .led_green, .led_red);
